/* logic/sdc_cal_if.sv */
// Link between the reference/divider front end and the calibration timer.
// Assumes both ends share sys_clk_i.
`default_nettype none
interface sdc_cal_if;
    logic                           pfd_tick;
    logic                           start;
    logic [sdc_pkg::COARSE_W-1:0]   coarse;
    logic [sdc_pkg::FINE_W-1:0]     fine;
    logic [sdc_pkg::BDIV_W-1:0]     band_div;
    logic                           alc_done;
    logic                           settle_done;
    sdc_pkg::sdc_phase_t            phase;
    logic                           dac_hold;
    logic                           band_clk;
    logic [sdc_pkg::CYC_W-1:0]      step;
    logic                           done;
    modport ctrl  (output pfd_tick, start, coarse, fine, band_div, alc_done, settle_done,
                   input  phase, dac_hold, band_clk, step, done);
    modport timer (input  pfd_tick, start, coarse, fine, band_div, alc_done, settle_done,
                   output phase, dac_hold, band_clk, step, done);
endinterface
`default_nettype wire

/* logic/sdc_cal_timer.sv */
// Lock sequencer: settle timer, band-select stepper, then level cal and settling.
// Assumes pfd_tick is a one-cycle pulse on sys_clk per phase-detector cycle.
`default_nettype none
module sdc_cal_timer
(
    // Clock and reset
    input  wire logic    clk_i,
    input  wire logic    reset_i,
    // Front end link
    sdc_cal_if.timer     cal
);
    sdc_pkg::sdc_phase_t           next_phase;
    logic [sdc_pkg::SETTLE_W-1:0]  settle_cnt;
    logic [sdc_pkg::SETTLE_W-1:0]  settle_load;
    logic [sdc_pkg::BDIV_W-1:0]    div_cnt;
    logic [sdc_pkg::CYC_W-1:0]     cyc_cnt;
    logic                          band_tick;
    logic                          band_last;

    // Interval is coarse * 1024 + fine ticks
    assign settle_load = (sdc_pkg::SETTLE_W'(cal.coarse) << sdc_pkg::COARSE_SHIFT)
                       | sdc_pkg::SETTLE_W'(cal.fine);
    // One band clock per band_div phase-detector ticks
    assign band_tick = cal.pfd_tick && (cal.phase == sdc_pkg::PH_BAND)
                    && (div_cnt == cal.band_div - 8'h01);
    assign band_last = band_tick && (cyc_cnt == sdc_pkg::CYC_LAST) && (cal.step == sdc_pkg::STEP_LAST);

    // Phase sequencing; a new frequency change restarts from settle
    always_comb
    begin
        next_phase = cal.phase;
        if (cal.start)
            next_phase = sdc_pkg::PH_SYNTH;
        else
        begin
            unique case (cal.phase)
                sdc_pkg::PH_IDLE:   next_phase = sdc_pkg::PH_IDLE;
                sdc_pkg::PH_SYNTH:  if (cal.pfd_tick && settle_cnt == 15'h0001) next_phase = sdc_pkg::PH_BAND;
                sdc_pkg::PH_BAND:   if (band_last) next_phase = sdc_pkg::PH_ALC;
                sdc_pkg::PH_ALC:    if (cal.alc_done) next_phase = sdc_pkg::PH_SETTLE;
                sdc_pkg::PH_SETTLE: if (cal.settle_done) next_phase = sdc_pkg::PH_IDLE;
                default:            next_phase = sdc_pkg::PH_IDLE;
            endcase
        end
    end

    // State and phase-derived outputs
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cal.phase    <= sdc_pkg::PH_IDLE;
            cal.dac_hold <= 1'b0;
            cal.done     <= 1'b0;
        end
        else
        begin
            cal.phase    <= next_phase;
            cal.dac_hold <= (next_phase == sdc_pkg::PH_SYNTH);
            cal.done     <= (cal.phase == sdc_pkg::PH_SETTLE) && (next_phase == sdc_pkg::PH_IDLE);
        end
    end

    // Settle down-counter, loaded on start, clocked by pfd ticks
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            settle_cnt <= '0;
        else if (cal.start)
            settle_cnt <= settle_load;
        else if (cal.pfd_tick && cal.phase == sdc_pkg::PH_SYNTH && settle_cnt != '0)
            settle_cnt <= settle_cnt - 15'h0001;
    end

    // Band clock divider and step counters
    always_ff @(posedge clk_i)
    begin
        if (reset_i || cal.start)
        begin
            div_cnt      <= '0;
            cyc_cnt      <= '0;
            cal.step     <= '0;
            cal.band_clk <= 1'b0;
        end
        else
        begin
            cal.band_clk <= band_tick;
            if (cal.pfd_tick && cal.phase == sdc_pkg::PH_BAND)
                div_cnt <= band_tick ? '0 : div_cnt + 8'h01;
            if (band_tick)
            begin
                cyc_cnt <= cyc_cnt + 4'h1;
                if (cyc_cnt == sdc_pkg::CYC_LAST)
                    cal.step <= cal.step + 4'h1;
            end
        end
    end

    // Checks on the sequence
    sequence s_settle_end;
        cal.phase == sdc_pkg::PH_SYNTH && cal.pfd_tick && settle_cnt == 15'h0001 && !cal.start;
    endsequence
    sequence s_band_end;
        band_last && !cal.start;
    endsequence

    a_settle_load: assert property (@(posedge clk_i) disable iff (reset_i)
        cal.start |=> settle_cnt == $past(settle_load))
        else $error("settle count not loaded from coarse and fine");
    a_settle_exit: assert property (@(posedge clk_i) disable iff (reset_i)
        s_settle_end |=> cal.phase == sdc_pkg::PH_BAND && !cal.dac_hold)
        else $error("settle phase did not hand over to band select");
    a_hold_during: assert property (@(posedge clk_i) disable iff (reset_i)
        cal.dac_hold == (cal.phase == sdc_pkg::PH_SYNTH))
        else $error("dac hold out of step with settle phase");
    a_band_order: assert property (@(posedge clk_i) disable iff (reset_i)
        $changed(cal.phase) && cal.phase == sdc_pkg::PH_BAND |-> $past(cal.phase) == sdc_pkg::PH_SYNTH)
        else $error("band select entered out of order");
    a_band_done: assert property (@(posedge clk_i) disable iff (reset_i)
        s_band_end |=> cal.phase == sdc_pkg::PH_ALC ##0 cal.step == sdc_pkg::CYC_W'(sdc_pkg::BAND_STEPS))
        else $error("band select did not end after last step");
    a_band_clock: assert property (@(posedge clk_i) disable iff (reset_i)
        band_tick |=> cal.band_clk ##1 !cal.band_clk || cal.band_div == 8'h01)
        else $error("band clock pulse malformed");
endmodule
`default_nettype wire

/* logic/sdc_pkg.sv */
// Shared widths, limits and phase codes for the synthesizer control block.
// Assumes all users refer to names as sdc_pkg::name without import.
`default_nettype none
package sdc_pkg;
    // Divider word widths
    localparam int INT_W    = 16;
    localparam int PRIMARY_FRACTION_W  = 25;
    localparam int AUXILIARY_FRACTION_W  = 14;
    localparam int RDIV_W   = 5;
    // Settle timer fields; coarse weight is 1024 cycles
    localparam int COARSE_W     = 5;
    localparam int FINE_W       = 10;
    localparam int COARSE_SHIFT = 10;
    localparam int SETTLE_W     = 15;
    // Band-select stepping: 16 band clocks a step, 11 steps
    localparam int BDIV_W    = 8;
    localparam int CYC_W     = 4;
    localparam int BAND_CYCLES = 16;
    localparam int BAND_STEPS  = 11;
    localparam logic [CYC_W-1:0] CYC_LAST  = CYC_W'(BAND_CYCLES - 1);
    localparam logic [CYC_W-1:0] STEP_LAST = CYC_W'(BAND_STEPS - 1);
    // Lock sequence phases
    typedef enum logic [2:0] {PH_IDLE, PH_SYNTH, PH_BAND, PH_ALC, PH_SETTLE} sdc_phase_t;
endpackage
`default_nettype wire

/* logic/sdc_synth_ctrl.sv */
// Fractional-N synthesizer control: reference path to phase-detector rate,
// fractional feedback ratio sequencing and the lock calibration timer.
// Assumes ref_i is an asynchronous pin well below sys_clk_i / 4.
//
// Notes on behaviour
// - Average feedback ratio is int + (primary_fraction + auxiliary_fraction/auxiliary_modulus) / 2^25.
// - Phase-detector rate is ref times (1+doubler) over r_div times (1+halve).
// - Halve divides by two and gives a 50 percent duty phase-detector clock.
// - Doubler uses both reference edges, doubling the comparison rate.
// - Frequency change runs settle, band select, level cal, then loop settling.
// - Calibration DAC holds the tune voltage for the settle interval only.
// - Settle interval counts coarse*1024 + fine phase-detector cycles.
// - Band clock is the phase-detector clock divided by band_clock_divisor.
// - Band select takes 11 steps of 16 band clocks each.
// - Reference divider is 5 bits, ratios 1 to 32, zero meaning 32.
// - Auxiliary modulus and fraction are 14-bit values.
`default_nettype none
module sdc_synth_ctrl
(
    // Clock and reset
    input  wire logic                           sys_clk_i,
    input  wire logic                           reset_i,
    // Reference pin
    input  wire logic                           ref_i,
    // Reference path settings
    input  wire logic                           doubler_i,
    input  wire logic                           halve_i,
    input  wire logic [sdc_pkg::RDIV_W-1:0]     r_div_i,
    // Feedback ratio settings
    input  wire logic [sdc_pkg::INT_W-1:0]      int_i,
    input  wire logic [sdc_pkg::PRIMARY_FRACTION_W-1:0]    primary_fraction_i,
    input  wire logic [sdc_pkg::AUXILIARY_FRACTION_W-1:0]    auxiliary_fraction_i,
    input  wire logic [sdc_pkg::AUXILIARY_FRACTION_W-1:0]    auxiliary_modulus_i,
    // Calibration settings and handshakes
    input  wire logic [sdc_pkg::COARSE_W-1:0]   settle_coarse_count_i,
    input  wire logic [sdc_pkg::FINE_W-1:0]     settle_fine_count_i,
    input  wire logic [sdc_pkg::BDIV_W-1:0]     band_clock_divisor_i,
    input  wire logic                           freq_change_i,
    input  wire logic                           alc_done_i,
    input  wire logic                           settle_done_i,
    // Phase-detector outputs
    output logic                                pfd_clk_o,
    output logic                                pfd_tick_o,
    output logic [sdc_pkg::INT_W:0]             div_ratio_o,
    // Calibration status
    output sdc_pkg::sdc_phase_t                 phase_o,
    output logic                                dac_hold_o,
    output logic                                band_clk_o,
    output logic [sdc_pkg::CYC_W-1:0]           band_step_o,
    output logic                                cal_done_o
);
    logic                           ref_s1;
    logic                           ref_s2;
    logic                           ref_s3;
    logic                           ref_tick;
    logic [sdc_pkg::RDIV_W-1:0]     r_cnt;
    logic [sdc_pkg::RDIV_W-1:0]     r_last;
    logic                           r_tick;
    logic                           half_q;
    logic                           pfd_tick;
    logic [sdc_pkg::AUXILIARY_FRACTION_W-1:0]    acc2;
    logic [sdc_pkg::PRIMARY_FRACTION_W-1:0]    acc1;
    logic [sdc_pkg::AUXILIARY_FRACTION_W:0]      sum2;
    logic                           carry2;
    logic [sdc_pkg::PRIMARY_FRACTION_W:0]      sum1;

    sdc_cal_if cal ();

    // Two-flop synchroniser, third flop for edge detection
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_s3 <= 1'b0;
        end
        else
        begin
            ref_s1 <= ref_i;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
        end
    end

    // Edges are judged past the second flop so no metastable value reaches the counter
    // Doubler counts both edges, otherwise rising only
    assign ref_tick = doubler_i ? (ref_s2 ^ ref_s3) : (ref_s2 & ~ref_s3);
    // Zero wraps to 31 so a setting of zero divides by 32
    assign r_last = r_div_i - 5'h01;
    assign r_tick = ref_tick && (r_cnt == r_last);
    // Halving keeps every second divider output
    assign pfd_tick = halve_i ? (r_tick && half_q) : r_tick;

    // Reference counter; settings are live, so a ratio lowered below the count
    // wraps through 31 once before it matches again
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            r_cnt <= '0;
        else if (r_tick)
            r_cnt <= '0;
        else if (ref_tick)
            r_cnt <= r_cnt + 5'h01;
    end

    // Divide-by-two toggle and phase-detector clock outputs
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            half_q     <= 1'b0;
            pfd_clk_o  <= 1'b0;
            pfd_tick_o <= 1'b0;
        end
        else
        begin
            if (r_tick)
                half_q <= ~half_q;
            pfd_clk_o  <= halve_i ? half_q : r_tick;
            pfd_tick_o <= pfd_tick;
        end
    end

    // Two-stage fraction accumulator; the auxiliary carry adds one to acc1, the primary carry adds one to the ratio
    assign sum2   = {1'b0, acc2} + {1'b0, auxiliary_fraction_i};
    assign carry2 = (sum2 >= {1'b0, auxiliary_modulus_i});
    assign sum1   = {1'b0, acc1} + {1'b0, primary_fraction_i} + {{sdc_pkg::PRIMARY_FRACTION_W{1'b0}}, carry2};

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            acc2        <= '0;
            acc1        <= '0;
            div_ratio_o <= '0;
        end
        else if (pfd_tick)
        begin
            // Modulus over 2^25 is the natural wrap of acc1
            acc2        <= carry2 ? sdc_pkg::AUXILIARY_FRACTION_W'(sum2 - {1'b0, auxiliary_modulus_i}) : sum2[sdc_pkg::AUXILIARY_FRACTION_W-1:0];
            acc1        <= sum1[sdc_pkg::PRIMARY_FRACTION_W-1:0];
            div_ratio_o <= {1'b0, int_i} + {{sdc_pkg::INT_W{1'b0}}, sum1[sdc_pkg::PRIMARY_FRACTION_W]};
        end
    end

    // Timer link; settings are sampled live
    // No double buffering: the host must keep settings still during a sequence
    assign cal.pfd_tick    = pfd_tick;
    assign cal.start       = freq_change_i;
    assign cal.coarse      = settle_coarse_count_i;
    assign cal.fine        = settle_fine_count_i;
    assign cal.band_div    = band_clock_divisor_i;
    assign cal.alc_done    = alc_done_i;
    assign cal.settle_done = settle_done_i;
    assign phase_o         = cal.phase;
    assign dac_hold_o      = cal.dac_hold;
    assign band_clk_o      = cal.band_clk;
    assign band_step_o     = cal.step;
    assign cal_done_o      = cal.done;

    sdc_cal_timer u_timer
    (
        .clk_i   (sys_clk_i),
        .reset_i (reset_i),
        .cal     (cal.timer)
    );

    // Checks on the reference path and fraction
    a_rdiv_wrap: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        r_tick |=> r_cnt == 5'h00)
        else $error("reference counter did not wrap");
    a_double_edge: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        doubler_i && !ref_s2 && ref_s3 |-> ref_tick)
        else $error("falling edge ignored with doubler on");
    a_halve_skip: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        halve_i && r_tick && !half_q |-> !pfd_tick ##1 half_q)
        else $error("halver passed a tick it should drop");
    a_aux_bound: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        pfd_tick && $stable(auxiliary_modulus_i) && acc2 < auxiliary_modulus_i
        && auxiliary_fraction_i < auxiliary_modulus_i |=> acc2 < auxiliary_modulus_i)
        else $error("auxiliary accumulator escaped its modulus");
    a_ratio_step: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        pfd_tick |=> div_ratio_o == {1'b0, $past(int_i)} + 17'(!$past(sum1[sdc_pkg::PRIMARY_FRACTION_W]) ? 0 : 1))
        else $error("feedback ratio not int plus carry");

    // Output timing of the phase-detector pulse and clock
    a_tick_out: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        pfd_tick |=> pfd_tick_o)
        else $error("phase-detector pulse not registered out");
    a_tick_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !pfd_tick |=> !pfd_tick_o)
        else $error("phase-detector pulse without a tick");
    a_plain_clock: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !halve_i |=> pfd_clk_o == $past(r_tick))
        else $error("phase clock not the divider pulse");
    a_halve_clock: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        halve_i |=> pfd_clk_o == $past(half_q))
        else $error("halved phase clock not the toggle level");

    // Divider counting, halver pass, edge selection and ratio hold between ticks
    sequence s_halve_keep;
        pfd_tick ##1 !half_q;
    endsequence
    a_halve_pass: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        halve_i && r_tick && half_q |-> s_halve_keep)
        else $error("halver dropped a tick it should pass");
    a_rdiv_count: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        ref_tick && !r_tick |=> r_cnt == $past(r_cnt) + 5'h01)
        else $error("reference counter missed an edge");
    a_single_edge: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !doubler_i && ref_tick |-> ref_s2 && !ref_s3)
        else $error("falling edge counted with doubler off");
    a_ratio_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !pfd_tick |=> $stable(div_ratio_o))
        else $error("feedback ratio changed between ticks");
endmodule
`default_nettype wire

/* sim/sdc_synth_ctrl_tb_top.sv */
// Self-checking bench for the synthesizer control block.
// Assumes the design files under logic/ are compiled before this file.
`default_nettype none
module sdc_synth_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // Stimulus, all given a value at time zero
    logic                           sys_clk_i             = 1'b0;
    logic                           reset_i               = 1'b1;
    logic                           ref_i                 = 1'b0;
    logic                           doubler_i             = 1'b0;
    logic                           halve_i               = 1'b0;
    logic [sdc_pkg::RDIV_W-1:0]     r_div_i               = 5'h01;
    logic [sdc_pkg::INT_W-1:0]      int_i                 = 16'h0044;
    logic [sdc_pkg::PRIMARY_FRACTION_W-1:0]    primary_fraction_i    = 25'h0000000;
    logic [sdc_pkg::AUXILIARY_FRACTION_W-1:0]    auxiliary_fraction_i  = 14'h0000;
    logic [sdc_pkg::AUXILIARY_FRACTION_W-1:0]    auxiliary_modulus_i   = 14'h0002;
    logic [sdc_pkg::COARSE_W-1:0]   settle_coarse_count_i = 5'h02;
    logic [sdc_pkg::FINE_W-1:0]     settle_fine_count_i   = 10'h002;
    logic [sdc_pkg::BDIV_W-1:0]     band_clock_divisor_i  = 8'h01;
    logic                           freq_change_i         = 1'b0;
    logic                           alc_done_i            = 1'b0;
    logic                           settle_done_i         = 1'b0;
    // Observed outputs
    logic                           pfd_clk_o;
    logic                           pfd_tick_o;
    logic [sdc_pkg::INT_W:0]        div_ratio_o;
    sdc_pkg::sdc_phase_t            phase_o;
    logic                           dac_hold_o;
    logic                           band_clk_o;
    logic [sdc_pkg::CYC_W-1:0]      band_step_o;
    logic                           cal_done_o;
    // Bench bookkeeping
    int                             err_total   = 0;
    int                             check_count = 0;
    int                             cycle_count = 0;
    int                             ref_cnt     = 0;

    sdc_synth_ctrl u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .ref_i(ref_i), .doubler_i(doubler_i),
        .halve_i(halve_i), .r_div_i(r_div_i), .int_i(int_i), .primary_fraction_i(primary_fraction_i),
        .auxiliary_fraction_i(auxiliary_fraction_i), .auxiliary_modulus_i(auxiliary_modulus_i),
        .settle_coarse_count_i(settle_coarse_count_i), .settle_fine_count_i(settle_fine_count_i),
        .band_clock_divisor_i(band_clock_divisor_i), .freq_change_i(freq_change_i), .alc_done_i(alc_done_i),
        .settle_done_i(settle_done_i), .pfd_clk_o(pfd_clk_o), .pfd_tick_o(pfd_tick_o),
        .div_ratio_o(div_ratio_o), .phase_o(phase_o), .dac_hold_o(dac_hold_o), .band_clk_o(band_clk_o),
        .band_step_o(band_step_o), .cal_done_o(cal_done_o));

    // 10 MHz system clock
    always #50 sys_clk_i = ~sys_clk_i;

    // Free-running 1 MHz reference; 5 cycles per level keeps each edge visible to the synchroniser
    always @(negedge sys_clk_i)
    begin
        ref_cnt <= (ref_cnt == 4) ? 0 : ref_cnt + 1;
        if (ref_cnt == 4)
            ref_i <= ~ref_i;
    end

    // Hang guard, well above the roughly 41000 cycles the run needs
    always @(posedge sys_clk_i)
    begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 60000)
        begin
            err_total++;
            $display("[FAIL] %0t run timed out", $time);
            conclude();
        end
    end

    task automatic conclude();
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s: saw %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // Waits for the next tick pulse; n returns the cycles waited
    task automatic wait_tick(output int n);
        n = 0;
        do
        begin
            @(negedge sys_clk_i);
            n++;
        end while (pfd_tick_o !== 1'b1 && n < 4000);
        if (n >= 4000)
            check(32'h0, 32'h1, "no tick seen");
    endtask

    task automatic test_reset();
        repeat (20) @(negedge sys_clk_i);
        reset_i = 1'b0;
        @(negedge sys_clk_i);
        check({phase_o, dac_hold_o, cal_done_o, band_clk_o, pfd_tick_o}, 32'h0, "outputs after reset");
        check({band_step_o, div_ratio_o}, 32'h0, "counts after reset");
    endtask

    // Tick spacing and clock shape for one reference path setting
    task automatic test_ref(input logic d, input logic h, input logic [4:0] r);
        int n;
        int hi;
        int span;
        doubler_i = d;
        halve_i = h;
        r_div_i = r;
        span = 10 * ((r == 5'h00) ? 32 : int'(r)) * (h ? 2 : 1) / (d ? 2 : 1);
        repeat (3) wait_tick(n);
        hi = 0;
        n = 0;
        do
        begin
            @(negedge sys_clk_i);
            n++;
            hi += int'(pfd_clk_o === 1'b1);
        end while (pfd_tick_o !== 1'b1 && n < 4000);
        check(n, span, "tick spacing");
        check(hi, h ? span / 2 : 1, "phase clock high time");
    endtask

    // Sum of carries over 64 ticks; exact because 64 steps return the accumulators home
    task automatic test_frac(input logic [15:0] iv, input logic [24:0] f1, input logic [13:0] f2,
                             input logic [13:0] m2, input int carries);
        int n;
        logic [31:0] sum;
        int_i = iv;
        primary_fraction_i = f1;
        auxiliary_fraction_i = f2;
        auxiliary_modulus_i = m2;
        repeat (4) wait_tick(n);
        sum = 32'h0;
        repeat (64)
        begin
            wait_tick(n);
            sum = sum + 32'(div_ratio_o) - 32'(iv);
        end
        check(sum, carries, "feedback carry count");
    endtask

    // Lock sequence; a partial run stops in band select so the next call restarts it
    task automatic test_cal(input logic [4:0] co, input logic [9:0] fi, input logic [7:0] bd, input bit full);
        int n;
        logic [31:0] ticks;
        logic [31:0] bclk;
        bit hold_ok;
        settle_coarse_count_i = co;
        settle_fine_count_i = fi;
        band_clock_divisor_i = bd;
        wait_tick(n);
        freq_change_i = 1'b1;
        @(negedge sys_clk_i);
        freq_change_i = 1'b0;
        check(phase_o, sdc_pkg::PH_SYNTH, "start phase");
        ticks = 32'h0;
        hold_ok = 1'b1;
        n = 0;
        while (phase_o === sdc_pkg::PH_SYNTH && n < 40000)
        begin
            hold_ok &= (dac_hold_o === 1'b1);
            @(negedge sys_clk_i);
            n++;
            ticks = ticks + 32'(pfd_tick_o);
        end
        check(hold_ok, 1'b1, "hold during settle");
        check(ticks, 32'(co) * 1024 + 32'(fi), "settle length");
        check({phase_o, dac_hold_o}, {sdc_pkg::PH_BAND, 1'b0}, "band phase");
        if (full)
        begin
            ticks = 32'h0;
            bclk = 32'h0;
            n = 0;
            while (phase_o === sdc_pkg::PH_BAND && n < 40000)
            begin
                @(negedge sys_clk_i);
                n++;
                ticks = ticks + 32'(pfd_tick_o);
                bclk = bclk + 32'(band_clk_o);
            end
            check(bclk, 32'd176, "band clocks");
            check(ticks, 32'd176 * 32'(bd), "band select length");
            check(band_step_o, 4'hb, "band steps");
            check(phase_o, sdc_pkg::PH_ALC, "level cal phase");
            settle_done_i = 1'b1;
            @(negedge sys_clk_i);
            settle_done_i = 1'b0;
            check(phase_o, sdc_pkg::PH_ALC, "early settle flag ignored");
            alc_done_i = 1'b1;
            @(negedge sys_clk_i);
            alc_done_i = 1'b0;
            check({phase_o, cal_done_o}, {sdc_pkg::PH_SETTLE, 1'b0}, "settling phase");
            settle_done_i = 1'b1;
            @(negedge sys_clk_i);
            settle_done_i = 1'b0;
            check({phase_o, cal_done_o, dac_hold_o}, {sdc_pkg::PH_IDLE, 2'b10}, "sequence end");
            @(negedge sys_clk_i);
            check(cal_done_o, 1'b0, "done is one cycle");
        end
    endtask

    // Main sequence
    initial
    begin
        test_reset();
        test_ref(1'b0, 1'b0, 5'h00);
        test_ref(1'b0, 1'b0, 5'h01);
        test_ref(1'b0, 1'b1, 5'h01);
        test_ref(1'b0, 1'b0, 5'h03);
        test_ref(1'b1, 1'b1, 5'h03);
        test_ref(1'b1, 1'b0, 5'h01);
        test_frac(16'h0044, 25'h0800000, 14'h0000, 14'h0002, 16);
        test_frac(16'hffff, 25'h1ffffff, 14'h3fff, 14'h3fff, 64);
        test_frac(16'h0044, 25'h0000000, 14'h0000, 14'h0002, 0);
        test_cal(5'h02, 10'h002, 8'h02, 1'b1);
        test_cal(5'h02, 10'h3ff, 8'h01, 1'b0);
        test_cal(5'h02, 10'h007, 8'h01, 1'b1);
        conclude();
    end
endmodule
`default_nettype wire
